// [inc/abt_pkg.sv]
// constants, types and helpers of the automatic byte-transfer controller
// assumes one system clock and a synchronous active-low reset
package abt_pkg;
    localparam int PTR_W = 18;             // memory pointer width
    localparam int TRIG_N = 16;            // selectable trigger sources
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL0 = 16'h3FD0;
    localparam logic [15:0] IDX_CTRL1 = 16'h3FD1;
    localparam logic [15:0] IDX_COUNT = 16'h3FD2;
    localparam logic [15:0] IDX_P0L = 16'h3FD3;
    localparam logic [15:0] IDX_P0M = 16'h3FD4;
    localparam logic [15:0] IDX_P0H = 16'h3FD5;
    localparam logic [15:0] IDX_P1L = 16'h3FD6;
    localparam logic [15:0] IDX_P1M = 16'h3FD7;
    localparam logic [15:0] IDX_P1H = 16'h3FD8;
    localparam logic [15:0] IDX_STAT = 16'h3FD9;
    // field positions
    localparam int C0_FIX = 7;             // fixed_pointer_flag
    localparam int C0_ACT = 6;             // software_activate_flag
    localparam int C0_MODE_LSB = 2;        // transfer_mode_select 5:2
    localparam int C0_EN = 0;              // controller_enable_flag
    localparam int C1_BSTOP = 4;           // burst_stop_enable
    // reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 18'h00000;
    localparam logic [9:0] IO_PAGE = 10'h03F;  // upper ten io bits
    // transfer modes handled here
    typedef enum logic [3:0] {
        MD_9 = 4'h9, MD_A = 4'hA, MD_B = 4'hB,
        MD_C = 4'hC, MD_D = 4'hD, MD_E = 4'hE, MD_F = 4'hF
    } abt_mode_t;
    // next pointer value, wraps at the top of memory
    function automatic logic [PTR_W-1:0] ptr_inc(
        input logic [PTR_W-1:0] p);
        ptr_inc = p + 18'h00001;
    endfunction : ptr_inc
    // io address: fixed page, even base, odd on second move
    function automatic logic [PTR_W-1:0] io_addr(
        input logic [PTR_W-1:0] p1, input logic odd);
        io_addr = {IO_PAGE, p1[7:1], odd};
    endfunction : io_addr
endpackage : abt_pkg

// [inc/abt_if.sv]
// carriers between the controller core and its two helpers
// assumes all parties run on the one system clock
`timescale 1ns/100ps
`default_nettype none
// register access strobes from the bus slave
interface abt_reg_if;
    logic wr_stb;                          // write accepted this cycle
    logic [15:0] addr;                     // register index
    logic [7:0] wdata;                     // write byte
    logic [7:0] rdata;                     // read byte from core
    modport slv (output wr_stb, addr, wdata, input rdata);
    modport core (input wr_stb, addr, wdata, output rdata);
endinterface : abt_reg_if
// one byte move request to the mover
interface abt_move_if;
    import abt_pkg::*;
    logic req;                             // one-cycle start
    logic [PTR_W-1:0] src;                 // read address
    logic [PTR_W-1:0] dst;                 // write address
    logic done;                            // one-cycle finish
    modport ctl (output req, src, dst, input done);
    modport eng (input req, src, dst, output done);
endinterface : abt_move_if
`default_nettype wire

// [hdl/abt_avs_slave.sv]
// avalon-mm slave front end: one wait state per access
// assumes the master holds its request until waitrequest is low
`timescale 1ns/100ps
`default_nettype none
module abt_avs_slave import abt_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    abt_reg_if.slv rif
);
    logic ack_r;                           // answer cycle marker
    wire req = avs_read_in | avs_write_in; // any request pending
    assign avs_waitrequest_out = req & ~ack_r;
    assign rif.wr_stb = avs_write_in & ack_r;
    assign rif.addr = avs_address_in;
    assign rif.wdata = avs_writedata_in[7:0];
    // wait state gives the core a cycle to settle read data
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) ack_r <= 1'b0;
        else ack_r <= req & ~ack_r;
    end
    // read data captured in the wait cycle, stands at the answer
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) avs_readdata_out <= 32'h00000000;
        else if (avs_read_in & ~ack_r)
            avs_readdata_out <= {24'h000000, rif.rdata};
    end
endmodule : abt_avs_slave
`default_nettype wire

// [hdl/abt_mover.sv]
// byte mover: internal-bus read of source, then write of destination
// assumes the memory side answers each strobe with a one-cycle ack
`timescale 1ns/100ps
`default_nettype none
module abt_mover import abt_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    abt_move_if.eng mif,
    output logic [PTR_W-1:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_ack_in
);
    typedef enum logic [1:0] {
        MV_IDLE = 2'b00, MV_RD = 2'b01, MV_WR = 2'b11
    } abt_mv_t;
    abt_mv_t st_r;                         // mover state
    logic done_r;                          // finish pulse
    assign mif.done = done_r;
    // read strobe until ack, then write the same byte
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_r <= MV_IDLE;
            mem_addr_out <= PTR_RST;
            mem_rd_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_wdata_out <= REG_RST;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (st_r)
                MV_IDLE: if (mif.req) begin
                    mem_addr_out <= mif.src;
                    mem_rd_out <= 1'b1;
                    st_r <= MV_RD;
                end
                MV_RD: if (mem_ack_in) begin
                    mem_wdata_out <= mem_rdata_in;
                    mem_addr_out <= mif.dst;
                    mem_rd_out <= 1'b0;
                    mem_wr_out <= 1'b1;
                    st_r <= MV_WR;
                end
                MV_WR: if (mem_ack_in) begin
                    mem_wr_out <= 1'b0;
                    done_r <= 1'b1;
                    st_r <= MV_IDLE;
                end
                default: st_r <= MV_IDLE;  // code 10 unused
            endcase
        end
    end
    // read completes, then write carries that byte to the dst
    sequence s_rd_ack;
        mem_rd_out && mem_ack_in;
    endsequence
    sequence s_wr_same;
        mem_wr_out && !mem_rd_out && mem_wdata_out == $past(mem_rdata_in);
    endsequence
    chk_read_then_write: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) s_rd_ack |=> s_wr_same)
        else $error("write did not follow read with read byte");
endmodule : abt_mover
`default_nettype wire

// [hdl/abt_top.sv]
// controller core: registers, activation logic and transfer sequencer
// assumes on-chip trigger and irq0 flag come from this clock domain
`timescale 1ns/100ps
`default_nettype none
module abt_top import abt_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [TRIG_N-1:0] trigger_in,
    input wire logic ext_irq0_request_flag_in,
    output logic [PTR_W-1:0] mem_addr_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_ack_in,
    output logic transfer_done_irq_out
);
    // sequencer states, gray along idle-issue-wait
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b11
    } abt_st_t;

    abt_reg_if rif ();                     // bus to register file
    abt_move_if mif ();                    // core to mover

    // register bank
    logic [7:0] ctrl0_r, ctrl0_nxt;        // xfer_control_0
    logic [4:0] ctrl1_r;                   // xfer_control_1
    logic [7:0] count_r, count_nxt;        // transfer_count_reg
    logic [PTR_W-1:0] p0_r, p0_nxt;        // memory pointer 0
    logic [PTR_W-1:0] p1_r, p1_nxt;        // memory pointer 1
    abt_st_t st_r, st_nxt;                 // sequencer state
    logic phase_r, phase_nxt;              // second move of mode 9
    logic halted_r, halted_nxt;            // burst stopped by irq0
    logic irq_r;                           // completion pulse

    // bus slave front end
    abt_avs_slave u_avs (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .rif(rif)
    );

    // byte mover on the internal bus
    abt_mover u_mover (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .mif(mif),
        .mem_addr_out(mem_addr_out),
        .mem_rd_out(mem_rd_out),
        .mem_wr_out(mem_wr_out),
        .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(mem_rdata_in),
        .mem_ack_in(mem_ack_in)
    );

    // control field decode
    wire [3:0] mode = ctrl0_r[C0_MODE_LSB+3:C0_MODE_LSB];
    wire enabled = ctrl0_r[C0_EN];
    wire fixed_p0 = ctrl0_r[C0_FIX];
    wire is_m9 = mode == MD_9;
    wire is_burst = (mode == MD_E) | (mode == MD_F);
    wire is_known = mode >= MD_9;          // lower modes not built here
    wire p1_is_src = mode[0];              // p1 is source
    wire incr_mode = mode >= MD_C;         // C..F step both pointers
    wire busy = st_r != ST_IDLE;

    // write decode, each register one index
    wire wr = rif.wr_stb & ~busy;          // pointers locked while busy
    wire wr_c0 = rif.wr_stb & (rif.addr == IDX_CTRL0);
    wire wr_c1 = wr & (rif.addr == IDX_CTRL1);
    wire wr_cnt = wr & (rif.addr == IDX_COUNT);
    wire wr_p0l = wr & (rif.addr == IDX_P0L);
    wire wr_p0m = wr & (rif.addr == IDX_P0M);
    wire wr_p0h = wr & (rif.addr == IDX_P0H);
    wire wr_p1l = wr & (rif.addr == IDX_P1L);
    wire wr_p1m = wr & (rif.addr == IDX_P1M);
    wire wr_p1h = wr & (rif.addr == IDX_P1H);

    // activation: selected trigger or software flag
    wire trig = trigger_in[ctrl1_r[3:0]];
    wire want = trig | ctrl0_r[C0_ACT];
    // no start while disabled or with nothing left to count
    wire accept = (st_r == ST_IDLE) & want & enabled &
                  (count_r != 8'h00) & is_known;

    // addresses of the current move
    wire [PTR_W-1:0] io_a = io_addr(p1_r, phase_r);
    wire [PTR_W-1:0] src_a = is_m9 ? (phase_r ? p0_r : io_a)
                                   : (p1_is_src ? p1_r : p0_r);
    wire [PTR_W-1:0] dst_a = is_m9 ? (phase_r ? io_a : p0_r)
                                   : (p1_is_src ? p0_r : p1_r);
    assign mif.req = st_r == ST_ISSUE;
    assign mif.src = src_a;
    assign mif.dst = dst_a;

    // per-move bookkeeping
    wire moved = (st_r == ST_WAIT) & mif.done;
    wire last_move = ~is_m9 | phase_r;     // mode 9 counts after move 2
    wire step_p0 = ~fixed_p0 & (is_m9 ? ~phase_r : incr_mode);
    wire step_p1 = ~is_m9 & incr_mode;
    wire reach_zero = last_move & (count_r == 8'h01);
    wire stop_req = ctrl1_r[C1_BSTOP] & ext_irq0_request_flag_in;

    // sequencer next state
    always_comb begin
        st_nxt = st_r;
        phase_nxt = phase_r;
        halted_nxt = halted_r;
        unique case (st_r)
            ST_IDLE: if (accept) begin
                st_nxt = ST_ISSUE;
                phase_nxt = 1'b0;
                halted_nxt = 1'b0;         // resume from held state
            end
            ST_ISSUE: st_nxt = ST_WAIT;
            ST_WAIT: if (moved) begin
                if (!last_move) begin
                    st_nxt = ST_ISSUE;     // second move follows
                    phase_nxt = 1'b1;
                end else if (is_burst & ~reach_zero) begin
                    if (stop_req) begin
                        st_nxt = ST_IDLE;
                        halted_nxt = 1'b1;
                    end else begin
                        st_nxt = ST_ISSUE; // back to back
                    end
                end else begin
                    st_nxt = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;     // code 10 unused
        endcase
    end

    // pointer and counter updates, engine first, software while idle
    always_comb begin
        p0_nxt = p0_r;
        p1_nxt = p1_r;
        count_nxt = count_r;
        if (moved) begin
            if (step_p0) p0_nxt = ptr_inc(p0_r);
            if (step_p1) p1_nxt = ptr_inc(p1_r);
            if (last_move) count_nxt = count_r - 8'h01;
        end else begin
            if (wr_p0l) p0_nxt[7:0] = rif.wdata;
            if (wr_p0m) p0_nxt[15:8] = rif.wdata;
            if (wr_p0h) p0_nxt[17:16] = rif.wdata[1:0];
            if (wr_p1l) p1_nxt[7:0] = rif.wdata;
            if (wr_p1m) p1_nxt[15:8] = rif.wdata;
            if (wr_p1h) p1_nxt[17:16] = rif.wdata[1:0];
            if (wr_cnt) count_nxt = rif.wdata;
        end
    end

    // control 0: software write sets the activate flag, acceptance
    // clears it; a write in the accept cycle wins so none is lost
    always_comb begin
        ctrl0_nxt = ctrl0_r;
        if (accept) ctrl0_nxt[C0_ACT] = 1'b0;
        if (wr_c0) begin
            ctrl0_nxt = {rif.wdata[7:2], 1'b0, rif.wdata[0]};
            if (!rif.wdata[C0_ACT] && accept)
                ctrl0_nxt[C0_ACT] = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_r <= ST_IDLE;
            phase_r <= 1'b0;
            halted_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            phase_r <= phase_nxt;
            halted_r <= halted_nxt;
        end
    end

    // data registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            p0_r <= PTR_RST;
            p1_r <= PTR_RST;
            count_r <= REG_RST;
        end else begin
            p0_r <= p0_nxt;
            p1_r <= p1_nxt;
            count_r <= count_nxt;
        end
    end

    // control registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ctrl0_r <= REG_RST;
            ctrl1_r <= REG_RST[4:0];
        end else begin
            ctrl0_r <= ctrl0_nxt;
            if (wr_c1) ctrl1_r <= rif.wdata[4:0];
        end
    end

    // completion pulse, one cycle as the counter reaches zero
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) irq_r <= 1'b0;
        else irq_r <= moved & reach_zero;
    end
    assign transfer_done_irq_out = irq_r;

    // read mux; unmapped indices read zero
    always_comb begin
        unique case (rif.addr)
            IDX_CTRL0: rif.rdata = ctrl0_r;
            IDX_CTRL1: rif.rdata = {3'h0, ctrl1_r};
            IDX_COUNT: rif.rdata = count_r;
            IDX_P0L: rif.rdata = p0_r[7:0];
            IDX_P0M: rif.rdata = p0_r[15:8];
            IDX_P0H: rif.rdata = {6'h00, p0_r[17:16]};
            IDX_P1L: rif.rdata = p1_r[7:0];
            IDX_P1M: rif.rdata = p1_r[15:8];
            IDX_P1H: rif.rdata = {6'h00, p1_r[17:16]};
            IDX_STAT: rif.rdata = {6'h00, halted_r, busy};
            default: rif.rdata = 8'h00;
        endcase
    end

    // checks
    sequence s_m9_second;
        st_r == ST_ISSUE && is_m9 && phase_r;
    endsequence
    chk_m9_odd_io: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        s_m9_second |-> mif.dst[0] && mif.src == p0_r)
        else $error("mode 9 second move not to odd io address");

    chk_io_page: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (st_r == ST_ISSUE && is_m9 && !phase_r)
        |-> mif.src[17:8] == IO_PAGE && !mif.src[0] && mif.dst == p0_r)
        else $error("io access left the io page");

    chk_m9_p0_step: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_m9 && !phase_r && !fixed_p0)
        |=> p0_r == $past(p0_r) + 18'h00001 && phase_r)
        else $error("mode 9 pointer 0 did not step after move 1");

    chk_m9_p0_hold: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_m9 && phase_r) |=> p0_r == $past(p0_r))
        else $error("mode 9 pointer 0 moved after move 2");

    chk_fixed_p0: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && fixed_p0) |=> p0_r == $past(p0_r))
        else $error("pointer 0 stepped with fixed flag set");

    chk_ab_fixed: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && (mode == MD_A || mode == MD_B))
        |=> p0_r == $past(p0_r) && p1_r == $past(p1_r)
            && count_r == $past(count_r) - 8'h01)
        else $error("fixed mode changed a pointer");

    chk_irq_zero: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        transfer_done_irq_out |-> count_r == 8'h00 && st_r == ST_IDLE)
        else $error("completion irq without zero count");

    chk_ignore_off: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (st_r == ST_IDLE && (!enabled || count_r == 8'h00))
        |=> st_r == ST_IDLE)
        else $error("trigger accepted while not allowed");

    chk_burst_halt: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_burst && stop_req && !reach_zero)
        |=> st_r == ST_IDLE && halted_r ##1 count_r == $past(count_r))
        else $error("burst did not halt on irq0 flag");

    chk_burst_run: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_burst && !stop_req && !reach_zero)
        |=> st_r == ST_ISSUE ##1 st_r == ST_WAIT)
        else $error("burst did not continue back to back");
    chk_act_clear: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (accept && !wr_c0) |=> !ctrl0_r[C0_ACT] && st_r == ST_ISSUE)
        else $error("activate flag not cleared on acceptance");

    // modes C and D step both pointers after the byte
    chk_cd_step: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && (mode == MD_C || mode == MD_D) && !fixed_p0)
        |=> p0_r == $past(p0_r) + 18'h00001
            && p1_r == $past(p1_r) + 18'h00001)
        else $error("mode C or D pointers did not step");

    // burst modes step pointer 1 after every byte
    chk_ef_step: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_burst) |=> p1_r == $past(p1_r) + 18'h00001)
        else $error("burst pointer 1 did not step");

    // every burst byte takes one count
    chk_burst_count: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_burst) |=> count_r == $past(count_r) - 8'h01)
        else $error("burst byte did not decrement the count");

    // mode 9 counts once, after the second move only
    chk_m9_count: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_m9)
        |=> count_r == $past(count_r) - {7'h00, $past(phase_r)})
        else $error("mode 9 count step wrong");

    // mode 9 never steps pointer 1
    chk_m9_p1_hold: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && is_m9) |=> p1_r == $past(p1_r))
        else $error("mode 9 stepped pointer 1");

    // completion pulse lasts exactly one cycle
    sequence s_irq_once;
        transfer_done_irq_out ##1 !transfer_done_irq_out;
    endsequence
    chk_irq_pulse: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in)
        (moved && reach_zero) |=> s_irq_once)
        else $error("completion irq missing or too long");
endmodule : abt_top
`default_nettype wire

// [sim/abt_mem_model.sv]
// memory-side partner: answers each read or write strobe with an ack
// assumes strobes held until ack; read data valid only with the ack
`timescale 1ns/100ps
`default_nettype none
module abt_mem_model import abt_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [PTR_W-1:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [1:0] lat_in,
    output logic [7:0] rdata_out,
    output logic ack_out
);
    logic [1:0] wait_r; // cycles waited on this strobe
    // one-cycle ack; data inverted afterwards so stale reads show
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || ack_out || !(rd_in || wr_in)) begin
            ack_out <= 1'b0;
            wait_r <= 2'h0;
            rdata_out <= ~rdata_out;
        end else if (wait_r >= lat_in) begin
            ack_out <= 1'b1;
            rdata_out <= addr_in[7:0] ^ 8'hA5;
        end else begin
            wait_r <= wait_r + 2'h1; // slow answer
        end
    end
endmodule : abt_mem_model
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench: bus tasks predict moves, a watcher compares
// assumes one clock; memory side is the partner model
`timescale 1ns/100ps
`default_nettype none
module tb_top import abt_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, irq0 = 1'b0;
    logic [15:0] adr = 16'h0, trig = 16'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic wrq, mrd, mwr, mack, irq;
    logic [17:0] madr, p0, p1;
    logic [7:0] mwd, mrdat, rnd = 8'd60;
    logic [1:0] lat = 2'h0;
    logic [26:0] exp_q[$]; // expected {write, addr, data}
    int bad_count = 0, cmp_count = 0, irq_n = 0;
    abt_top u_dut (.mclk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wrq),
        .trigger_in(trig), .ext_irq0_request_flag_in(irq0),
        .mem_addr_out(madr), .mem_rd_out(mrd), .mem_wr_out(mwr),
        .mem_wdata_out(mwd), .mem_rdata_in(mrdat), .mem_ack_in(mack),
        .transfer_done_irq_out(irq));
    abt_mem_model u_mem (.mclk_in(clk), .rst_n_in(rst_n), .addr_in(madr),
        .rd_in(mrd), .wr_in(mwr), .lat_in(lat), .rdata_out(mrdat),
        .ack_out(mack));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp
    // watcher: every acked memory strobe takes the oldest note
    always @(posedge clk) begin
        if (irq === 1'b1) irq_n++;
        if (mack === 1'b1 && (mrd || mwr)) begin
            if (exp_q.size() == 0) cmp(32'h1, 32'h0);
            else cmp({mwr, madr, mwr ? mwd : mrdat}, exp_q.pop_front());
        end
    end
    // one avalon access, held until waitrequest seen low
    task automatic bus(input logic w, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        logic ws;
        n = 0;
        ws = 1'b1;
        @(posedge clk);
        adr <= a;
        wd <= {24'h0, d};
        wr <= w;
        rd <= !w;
        while (ws && n < 50) begin
            @(posedge clk);
            ws = wrq;
            q = rdat[7:0];
            n++;
        end
        if (ws !== 1'b0) begin bad_count++; close_out(); end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic move(input logic [17:0] s, input logic [17:0] d);
        exp_q.push_back({1'b0, s, s[7:0] ^ 8'hA5});
        exp_q.push_back({1'b1, d, s[7:0] ^ 8'hA5});
    endtask : move
    // expected moves of one activation or one burst byte
    task automatic predict(input logic [3:0] m, input logic fx);
        logic [17:0] io;
        io = {10'h03F, p1[7:1], 1'b0};
        case (m)
            4'h9: begin
                move(io, p0);
                if (!fx) p0++;
                move(p0, io | 18'h1);
            end
            4'hA, 4'hC, 4'hE: move(p0, p1);
            default: move(p1, p0);
        endcase
        if (m >= 4'hC) begin
            if (!fx) p0++;
            p1++;
        end
    endtask : predict
    // poll until status reads want; for zero also until all notes consumed
    task automatic settle(input logic [7:0] want);
        logic [7:0] q;
        int n;
        n = 0;
        q = 8'hFF;
        while ((q !== want || (want == 0 && exp_q.size() != 0)) && n < 200) begin
            bus(1'b0, IDX_STAT, 8'h00, q);
            n++;
        end
        cmp(q, want);
        if (want == 8'h00) cmp(exp_q.size(), 0);
    endtask : settle
    task automatic kick(input logic tr, input logic [7:0] c0);
        logic [7:0] q;
        if (tr) begin
            @(posedge clk);
            trig <= 16'h1 << rnd[3:0];
            @(posedge clk);
            trig <= 16'h0;
        end else bus(1'b1, IDX_CTRL0, c0 | 8'h40, q);
    endtask : kick
    // stp: bit0 burst stop enable, bit1 irq0 flag level
    task automatic run(input logic [3:0] m, input logic fx,
        input logic [7:0] cnt, input logic tr, input logic [1:0] stp);
        logic [7:0] q, c0, pb[6];
        rnd = lfsr(rnd);
        lat <= rnd[5:4];
        p0 = {2'h2, lfsr(rnd), rnd};
        p1 = {2'h1, 8'h30, rnd & 8'hFE};
        pb = '{p0[7:0], p0[15:8], {6'h0, p0[17:16]},
            p1[7:0], p1[15:8], {6'h0, p1[17:16]}};
        c0 = {fx, 1'b0, m, 1'b0, 1'b1};
        bus(1'b1, IDX_CTRL0, 8'h00, q);
        for (int i = 0; i < 6; i++) bus(1'b1, IDX_P0L + 16'(i), pb[i], q);
        bus(1'b1, IDX_COUNT, cnt, q);
        bus(1'b1, IDX_CTRL1, {3'h0, stp[0], rnd[3:0]}, q);
        bus(1'b1, IDX_CTRL0, c0, q);
        irq0 <= stp[1];
        irq_n = 0;
        for (int k = 0; k < (m >= 4'hE ? 1 : int'(cnt)); k++) begin
            if (m >= 4'hE) repeat (cnt) predict(m, fx);
            else predict(m, fx);
            kick(tr, c0);
            if (stp == 2'h3) begin
                settle(8'h02);
                irq0 <= 1'b0;
                kick(tr, c0);
            end
            settle(8'h00);
        end
        bus(1'b0, IDX_COUNT, 8'h00, q);
        cmp(q, 8'h00);
        cmp(irq_n, 1);
        bus(1'b0, IDX_P0L, 8'h00, q);
        cmp(q, p0[7:0]);
        bus(1'b0, IDX_P1L, 8'h00, q);
        cmp(q, p1[7:0]);
        bus(1'b0, IDX_CTRL0, 8'h00, q);
        cmp(q, c0);
    endtask : run
    initial begin
        logic [7:0] q;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int m = 9; m < 16; m++) run(4'(m), 1'b0, 8'd2, m[0], 2'h0);
        run(4'hC, 1'b1, 8'd2, 1'b0, 2'h0);
        run(4'h9, 1'b1, 8'd1, 1'b1, 2'h0);
        run(4'hE, 1'b0, 8'd3, 1'b0, 2'h3);
        run(4'hF, 1'b0, 8'd3, 1'b1, 2'h2);
        bus(1'b1, IDX_CTRL0, 8'h69, q);
        bus(1'b0, IDX_CTRL0, 8'h00, q);
        cmp(q, 8'h69);
        bus(1'b1, IDX_CTRL0, 8'h68, q);
        bus(1'b1, IDX_COUNT, 8'h01, q);
        bus(1'b0, IDX_CTRL0, 8'h00, q);
        cmp(q, 8'h68);
        bus(1'b1, IDX_CTRL0, 8'h61, q);
        settle(8'h00);
        bus(1'b0, IDX_CTRL0, 8'h00, q);
        cmp(q, 8'h61);
        bus(1'b0, 16'h3FDA, 8'h00, q);
        cmp(q, 8'h00);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
